// ### rtl/fault_response_manager.sv
// dual-channel fault and warning manager with per-fault response
// assumes async detector inputs; host commands on this clock
`timescale 1ns/1ps

// Function
// RQ1: each detected condition sets its status bit
// RQ2: clear, channel off or reset clears status
// RQ3: host clears both pages together
// RQ4: unmasked status bit asserts the alert line
// RQ5: alert response returns own address
// RQ6: paged faults per channel, local shutdown
// RQ7: latch-off needs enable off then on
// RQ8: shared fault stops both channels
// RQ9: warnings never stop conversion
// RQ10: ignore response acts as warning
// RQ11: latch-off stops now, restart with delay
// RQ12: option picks last or boot code
// RQ13: hysteretic restarts when fault clears; a hysteretic tracking overvoltage response retries as hiccup instead
// RQ14: hiccup waits interval then retries
// RQ15: fault shutdown skips turn-off delay
// RQ16: prebias overvoltage latches until power cycle
// RQ17: fixed overvoltage while disabled needs power cycle
// RQ18: tracking overvoltage fault pulls outputs low
// RQ19: tracking overvoltage warning after latency
// RQ20: tracking undervoltage warning
// RQ21: shutdown drops the ready output
// RQ22: present fault re-triggers after clear
// RQ23: detectors qualified by persistence counters
module fault_response_manager
#(
    parameter int HICCUP_CYCLES  = fault_pkg::HICCUP_CYC,
    parameter int PREBIAS_CYCLES = fault_pkg::PREBIAS_CYC,
    parameter logic [6:0] OWN_ADDRESS = 7'h2A  // arbitrary value
)
(
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst,
    // detector comparators and init done flag, asynchronous
    input  wire fault_pkg::det_s [1:0]           detRaw,
    input  wire logic                            prebiasOvRaw,
    input  wire logic                            initDone,
    // host control
    input  wire fault_pkg::cfg_s [1:0]           cfg,
    input  wire logic [1:0]                      enableCmd,
    input  wire logic [1:0]                      clearFaults,
    input  wire logic                            alertResponseReq,
    // outputs
    output logic [1:0]                           pwmEnable,
    output logic [1:0]                           regulatorReadyOutput,
    output logic [1:0][fault_pkg::STAT_W-1:0]    status,
    output logic                                 prebiasStatus,
    output logic                                 smbAlert_n,
    output logic                                 faultOutputPin_n,
    output logic [1:0][fault_pkg::CODE_W-1:0]    targetVoltageCode,
    output logic                                 alertResponseValid,
    output logic [6:0]                           alertResponseAddr
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [9:0] syncA;
    logic [9:0] syncB;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            syncA <= 10'h000;
            syncB <= 10'h000;
        end
        else
        begin
            syncA <= {prebiasOvRaw, initDone, detRaw};
            syncB <= syncA;
        end
    end

    fault_pkg::det_s [1:0] det;
    logic prebiasSync;
    logic initSync;
    assign det         = syncB[7:0];
    assign initSync    = syncB[8];
    assign prebiasSync = syncB[9];

    // ----------------------------------------
    // persistence counters
    // ----------------------------------------
    localparam int PW = 9;
    localparam logic [PW-1:0] LIM_FIX  = PW'(fault_pkg::FIXED_OV_CYC);
    localparam logic [PW-1:0] LIM_TOV  = PW'(fault_pkg::TRACK_OV_CYC);
    localparam logic [PW-1:0] LIM_WARN = PW'(fault_pkg::TRACK_WARN_CYC);

    logic [1:0][3:0][PW-1:0] pers;
    logic [1:0][3:0][PW-1:0] next_pers;
    logic [1:0][3:0]         qual;
    logic [1:0][3:0]         gate;
    logic [PW-1:0]           lim [4];

    assign lim[3] = LIM_FIX;
    assign lim[2] = LIM_TOV;
    assign lim[1] = LIM_WARN;
    assign lim[0] = LIM_WARN;

    // ----------------------------------------
    // channel state
    // ----------------------------------------
    fault_pkg::chan_e [1:0]  state;
    fault_pkg::chan_e [1:0]  next_state;
    logic [1:0][31:0]        timer;
    logic [1:0][31:0]        next_timer;
    logic [1:0]              enPrev;
    logic [1:0]              offSeen;
    logic [1:0]              next_offSeen;
    logic [1:0]              pcLock;
    logic [1:0]              next_pcLock;
    logic [1:0]              useBoot;
    logic [1:0]              next_useBoot;
    logic [1:0][fault_pkg::STAT_W-1:0] next_status;
    logic [1:0]              next_pwm;
    logic [1:0]              next_ready;
    logic [1:0][fault_pkg::CODE_W-1:0] next_code;
    logic                    next_prebias;
    logic [31:0]             pbTimer;
    logic [31:0]             next_pbTimer;
    logic                    next_alert_n;
    logic                    next_fault_n;
    logic                    next_araValid;

    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            // detector enable windows
            gate[c][3] = initSync;
            gate[c][2] = state[c] == fault_pkg::CH_RUN;
            gate[c][1] = state[c] == fault_pkg::CH_RUN;
            gate[c][0] = state[c] == fault_pkg::CH_RUN;
            for (int f = 0; f < 4; f++)
            begin
                // level must persist for the latency  (see RQ23)
                if (!(det[c][f] && gate[c][f]))
                    next_pers[c][f] = '0;
                else if (pers[c][f] < lim[f])
                    next_pers[c][f] = pers[c][f] + PW'(1);
                else
                    next_pers[c][f] = pers[c][f];
                qual[c][f] = det[c][f] && gate[c][f] && (pers[c][f] >= lim[f] - PW'(1));
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pers <= '0;
        else
            pers <= next_pers;
    end

    // ----------------------------------------
    // fault responses
    // ----------------------------------------
    always_comb
    begin
        logic          sharedTrip;
        logic          tripFix;
        logic          tripTov;
        logic          trip;
        logic          stillBad;
        fault_pkg::resp_e resp;
        sharedTrip = 1'b0;
        tripFix    = 1'b0;
        tripTov    = 1'b0;
        trip       = 1'b0;
        stillBad   = 1'b0;
        resp       = fault_pkg::RESP_IGNORE;
        // prebias check before init, cleared only by reset  (see RQ16)
        next_prebias = prebiasStatus;
        next_pbTimer = pbTimer;
        if (!initSync && pbTimer < 32'(PREBIAS_CYCLES))
        begin
            next_pbTimer = pbTimer + 32'h1;
            if (prebiasSync)
                next_prebias = 1'b1;
        end
        sharedTrip = next_prebias;
        next_fault_n = !next_prebias;
        for (int c = 0; c < 2; c++)
        begin
            next_state[c]   = state[c];
            next_timer[c]   = timer[c];
            next_offSeen[c] = offSeen[c] | !enableCmd[c];
            next_pcLock[c]  = pcLock[c];
            next_useBoot[c] = useBoot[c];
            // set wins over clear  (see RQ1) (see RQ22)
            next_status[c]  = status[c];
            if (clearFaults[c] || (enPrev[c] && !enableCmd[c]))
                next_status[c] = '0;  // see RQ2
            if (pcLock[c])
                next_status[c][3] = 1'b1;
            next_status[c] = next_status[c] | qual[c];  // see RQ6 RQ9 RQ19 RQ20
            tripFix = qual[c][3] && cfg[c].fixedOvResp != fault_pkg::RESP_IGNORE;
            tripTov = qual[c][2] && cfg[c].trackOvResp != fault_pkg::RESP_IGNORE;  // see RQ10 RQ18
            trip    = tripFix || tripTov;
            resp    = tripFix ? cfg[c].fixedOvResp : cfg[c].trackOvResp;
            if (tripTov && resp == fault_pkg::RESP_HYSTERETIC)
                resp = fault_pkg::RESP_HICCUP;
            // fixed trip while disabled locks until power cycle  (see RQ17)
            if (qual[c][3] && !enableCmd[c])
                next_pcLock[c] = 1'b1;
            stillBad = det[c].fixedOv || det[c].trackOv;
            if (sharedTrip || pcLock[c])
                next_state[c] = fault_pkg::CH_LATCHED;  // see RQ8
            else if (trip && state[c] != fault_pkg::CH_LATCHED)
            begin
                // immediate stop, no turn-off delay  (see RQ15)
                next_offSeen[c] = !enableCmd[c];
                next_timer[c]   = 32'h0;
                next_useBoot[c] = cfg[c].restartBootSelect;  // see RQ12
                case (resp)
                    fault_pkg::RESP_LATCH:      next_state[c] = fault_pkg::CH_LATCHED;  // see RQ11
                    fault_pkg::RESP_HYSTERETIC: next_state[c] = fault_pkg::CH_HYST;
                    default:                    next_state[c] = fault_pkg::CH_HICCUP;
                endcase
            end
            else
            begin
                case (state[c])
                    fault_pkg::CH_OFF:
                    begin
                        next_timer[c] = 32'h0;
                        if (enableCmd[c] && initSync)
                            next_state[c] = fault_pkg::CH_TON;
                    end
                    fault_pkg::CH_TON:
                    begin
                        next_timer[c] = timer[c] + 32'h1;
                        if (!enableCmd[c])
                            next_state[c] = fault_pkg::CH_OFF;
                        else if (timer[c] >= 32'(cfg[c].tonDelay))
                            next_state[c] = fault_pkg::CH_RUN;
                    end
                    fault_pkg::CH_RUN:
                    begin
                        if (!enableCmd[c])
                        begin
                            next_state[c]   = fault_pkg::CH_OFF;
                            next_useBoot[c] = 1'b0;
                        end
                    end
                    fault_pkg::CH_LATCHED:
                    begin
                        // only an off then on restarts  (see RQ7)
                        if (offSeen[c] && enableCmd[c])
                            next_state[c] = fault_pkg::CH_TON;
                    end
                    fault_pkg::CH_HYST:
                    begin
                        if (!enableCmd[c])
                            next_state[c] = fault_pkg::CH_OFF;
                        else if (!stillBad)
                            next_state[c] = fault_pkg::CH_TON;  // see RQ13
                    end
                    fault_pkg::CH_HICCUP:
                    begin
                        next_timer[c] = timer[c] + 32'h1;
                        if (!enableCmd[c])
                            next_state[c] = fault_pkg::CH_OFF;
                        else if (timer[c] >= 32'(HICCUP_CYCLES - 1))
                        begin
                            next_state[c] = fault_pkg::CH_TON;  // see RQ14
                            next_timer[c] = 32'h0;
                        end
                    end
                    default: next_state[c] = fault_pkg::CH_OFF;
                endcase
            end
            next_pwm[c]   = next_state[c] == fault_pkg::CH_RUN || next_state[c] == fault_pkg::CH_TON;
            next_ready[c] = next_state[c] == fault_pkg::CH_RUN;  // see RQ21
            next_code[c]  = next_useBoot[c] ? cfg[c].bootVoltageValue : cfg[c].programmedCode;
            if (next_pcLock[c] || (trip && resp != fault_pkg::RESP_IGNORE))
                next_fault_n = 1'b0;
        end
        // masked bits do not reach the alert line  (see RQ4)
        next_alert_n = !(|(next_status[0] & ~cfg[0].alertMask) || |(next_status[1] & ~cfg[1].alertMask)
                         || next_prebias);
        // answer the alert response with own address  (see RQ5)
        next_araValid = alertResponseReq && !smbAlert_n;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state                <= '{fault_pkg::CH_OFF, fault_pkg::CH_OFF};
            timer                <= '0;
            enPrev               <= 2'h0;
            offSeen              <= 2'h0;
            pcLock               <= 2'h0;
            useBoot              <= 2'h0;
            status               <= '0;
            prebiasStatus        <= 1'b0;
            pbTimer              <= 32'h0;
            pwmEnable            <= 2'h0;
            regulatorReadyOutput <= 2'h0;
            targetVoltageCode    <= '0;
            smbAlert_n           <= 1'b1;
            faultOutputPin_n     <= 1'b1;
            alertResponseValid   <= 1'b0;
            alertResponseAddr    <= 7'h00;
        end
        else
        begin
            state                <= next_state;
            timer                <= next_timer;
            enPrev               <= enableCmd;
            offSeen              <= next_offSeen;
            pcLock               <= next_pcLock;
            useBoot              <= next_useBoot;
            status               <= next_status;
            prebiasStatus        <= next_prebias;
            pbTimer              <= next_pbTimer;
            pwmEnable            <= next_pwm;
            regulatorReadyOutput <= next_ready;
            targetVoltageCode    <= next_code;
            smbAlert_n           <= next_alert_n;
            faultOutputPin_n     <= next_fault_n;
            alertResponseValid   <= next_araValid;
            alertResponseAddr    <= OWN_ADDRESS;
        end
    end

endmodule // fault_response_manager

// ### rtl/fault_pkg.sv
// fault manager constants and carrier types
// assumes a single 125 MHz clock domain
package fault_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ        = 125;
    localparam int PREBIAS_US     = 350;
    localparam int FIXED_OV_NS    = 1000;
    localparam int TRACK_OV_NS    = 1000;
    localparam int TRACK_WARN_NS  = 2000;
    localparam int HICCUP_MS      = 25;
    localparam int FIXED_OV_CYC   = (FIXED_OV_NS * CLK_MHZ + 999) / 1000;
    localparam int TRACK_OV_CYC   = (TRACK_OV_NS * CLK_MHZ + 999) / 1000;
    localparam int TRACK_WARN_CYC = (TRACK_WARN_NS * CLK_MHZ + 999) / 1000;
    localparam int PREBIAS_CYC    = PREBIAS_US * CLK_MHZ;
    localparam int HICCUP_CYC     = HICCUP_MS * 1000 * CLK_MHZ;
    localparam int TON_DELAY_W    = 16;
    localparam int CODE_W         = 8;

    // ----------------------------------------
    // response and channel state encoding
    // ----------------------------------------
    typedef enum logic [1:0] {
        RESP_IGNORE     = 2'b00,
        RESP_LATCH      = 2'b01,
        RESP_HYSTERETIC = 2'b10,
        RESP_HICCUP     = 2'b11
    } resp_e;

    typedef enum logic [2:0] {
        CH_OFF     = 3'b000,
        CH_TON     = 3'b001,
        CH_RUN     = 3'b010,
        CH_LATCHED = 3'b011,
        CH_HYST    = 3'b100,
        CH_HICCUP  = 3'b101
    } chan_e;

    // raw comparator outputs of one channel
    typedef struct packed {
        logic fixedOv;
        logic trackOv;
        logic trackOvWarn;
        logic trackUvWarn;
    } det_s;

    // sticky status of one channel; bit order matches det_s
    localparam int STAT_W = 4;

    // per-channel configuration
    typedef struct packed {
        resp_e                   fixedOvResp;
        resp_e                   trackOvResp;
        logic [STAT_W-1:0]       alertMask;
        logic                    restartBootSelect;
        logic [TON_DELAY_W-1:0]  tonDelay;
        logic [CODE_W-1:0]       programmedCode;
        logic [CODE_W-1:0]       bootVoltageValue;
    } cfg_s;

endpackage

// ### testbench/host_model.sv
// host model: alert response read, then an all-pages clear
// assumes serviceEn changes on the falling edge
`timescale 1ns/1ps
module host_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // bench control
    input  wire logic       serviceEn,
    output logic [6:0]      seenAddr,
    // alert and command side
    input  wire logic       smbAlert_n,
    input  wire logic       alertResponseValid,
    input  wire logic [6:0] alertResponseAddr,
    output logic            alertResponseReq,
    output logic [1:0]      clearFaults
);
    // ----------------------------------------
    // service sequence
    // ----------------------------------------
    logic [1:0] step;
    // falling edge, so the block samples settled commands
    always @(negedge clk or posedge rst)
    begin
        if (rst)
        begin
            step             <= 2'h0;
            seenAddr         <= 7'h00;
            alertResponseReq <= 1'b0;
            clearFaults      <= 2'h0;
        end
        else
        begin
            alertResponseReq <= 1'b0;
            clearFaults      <= 2'h0;
            if (alertResponseValid)
                seenAddr <= alertResponseAddr;
            case (step)
                2'h0: if (serviceEn && !smbAlert_n)
                begin
                    alertResponseReq <= 1'b1;
                    step             <= 2'h1;
                end
                2'h2:
                begin
                    clearFaults <= 2'h3;  // both pages together
                    step        <= 2'h3;
                end
                default: step <= step + 2'h1;
            endcase
        end
    end
endmodule  // host_model

// ### testbench/fault_response_manager_monitor.sv
// checker for the fault manager, sees only its ports
// assumes one clock, async active-high reset
`timescale 1ns/1ps
module fault_response_manager_monitor
#(
    parameter logic [6:0] OWN_ADDRESS = 7'h2A  // arbitrary value
)
(
    // clock and reset
    input wire logic                             clk,
    input wire logic                             rst,
    // watched inputs
    input wire fault_pkg::det_s [1:0]            detRaw,
    input wire fault_pkg::cfg_s [1:0]            cfg,
    input wire logic [1:0]                       enableCmd,
    input wire logic [1:0]                       clearFaults,
    input wire logic                             alertResponseReq,
    // watched outputs
    input wire logic [1:0]                       pwmEnable,
    input wire logic [1:0]                       regulatorReadyOutput,
    input wire logic [1:0][fault_pkg::STAT_W-1:0] status,
    input wire logic                             prebiasStatus,
    input wire logic                             smbAlert_n,
    input wire logic                             faultOutputPin_n,
    input wire logic                             alertResponseValid,
    input wire logic [6:0]                       alertResponseAddr
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [2:0] quiet;
    logic [2:0] next_quiet;
    logic       unmasked;
    // a clear holds only with no live condition
    always_comb next_quiet = (detRaw[0] != 4'h0) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    always_comb unmasked = |((status[0] & ~cfg[0].alertMask) | (status[1] & ~cfg[1].alertMask));
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            quiet <= 3'h0;
        else
            quiet <= next_quiet;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_allOff;
        pwmEnable == 2'b00 && !faultOutputPin_n;
    endsequence
    sequence s_chOff;
        !pwmEnable[0] && !faultOutputPin_n;
    endsequence
    property p_alert;
        unmasked [*2] |-> !smbAlert_n;
    endproperty
    property p_prebiasShut;
        $rose(prebiasStatus) |-> ##[0:1] s_allOff;
    endproperty
    property p_prebiasHold;
        prebiasStatus |=> prebiasStatus;
    endproperty
    property p_tonDelay;
        $rose(regulatorReadyOutput[0]) |-> $past(pwmEnable[0], 2);
    endproperty
    property p_warnRun;
        regulatorReadyOutput[0] && enableCmd[0] && $rose(status[0][0]) && status[0][3:2] == 2'b00 |=> pwmEnable[0];
    endproperty
    property p_clear;
        clearFaults[0] && quiet == 3'h7 |-> ##[1:2] status[0] == 4'h0;
    endproperty
    property p_ara;
        alertResponseReq && !smbAlert_n |=> alertResponseValid && alertResponseAddr == OWN_ADDRESS;
    endproperty
    property p_fixedStop;
        $rose(status[0][3]) && cfg[0].fixedOvResp != fault_pkg::RESP_IGNORE |-> ##[0:1] s_chOff;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not asserted");
    a_prebiasShut: assert property (p_prebiasShut) else $error("prebias shutdown missing");
    a_prebiasHold: assert property (p_prebiasHold) else $error("prebias status dropped");
    a_tonDelay: assert property (p_tonDelay) else $error("ready without turn-on delay");
    a_warnRun: assert property (p_warnRun) else $error("warning stopped conversion");
    a_clear: assert property (p_clear) else $error("clear left status set");
    a_ara: assert property (p_ara) else $error("alert response wrong");
    a_fixedStop: assert property (p_fixedStop) else $error("fault did not stop channel");
endmodule  // fault_response_manager_monitor

bind fault_response_manager fault_response_manager_monitor #(.OWN_ADDRESS(OWN_ADDRESS)) mon (
    .clk, .rst, .detRaw, .cfg, .enableCmd, .clearFaults, .alertResponseReq, .pwmEnable,
    .regulatorReadyOutput, .status, .prebiasStatus, .smbAlert_n, .faultOutputPin_n,
    .alertResponseValid, .alertResponseAddr);

// ### testbench/fault_response_manager_tb_top.sv
// self-checking bench: warnings, fault responses, alert service
// assumes the checker binds itself
`timescale 1ns/1ps
module fault_response_manager_tb_top;
    // ----------------------------------------
    // signals and tasks
    // ----------------------------------------
    logic clk, rst, prebiasOvRaw, initDone, serviceEn, m;
    logic alertResponseReq, alertResponseValid, prebiasStatus, smbAlert_n, faultOutputPin_n;
    logic [1:0] enableCmd, clearFaults, pwmEnable, regulatorReadyOutput;
    logic [6:0] alertResponseAddr, seenAddr;
    logic [1:0][fault_pkg::STAT_W-1:0] status;
    logic [1:0][fault_pkg::CODE_W-1:0] targetVoltageCode;
    fault_pkg::det_s [1:0] detRaw;
    fault_pkg::cfg_s [1:0] cfg;
    int nFail, checksDone, n, w;

    // short windows keep the run brief
    fault_response_manager #(.HICCUP_CYCLES(50), .PREBIAS_CYCLES(20)) uut (
        .clk, .rst, .detRaw, .prebiasOvRaw, .initDone, .cfg, .enableCmd, .clearFaults,
        .alertResponseReq, .pwmEnable, .regulatorReadyOutput, .status, .prebiasStatus, .smbAlert_n,
        .faultOutputPin_n, .targetVoltageCode, .alertResponseValid, .alertResponseAddr);
    host_model host (
        .clk, .rst, .serviceEn, .seenAddr, .smbAlert_n, .alertResponseValid,
        .alertResponseAddr, .alertResponseReq, .clearFaults);

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checksDone++;
        if (got !== exp)
        begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wt(int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic doReset();
        rst = 1'b1;
        wt(6);
        rst = 1'b0;
    endtask
    task automatic service();
        serviceEn <= 1'b1;
        wt(12);
        serviceEn <= 1'b0;
    endtask
    // bounded wait on pwm (r=0) or ready (r=1)
    task automatic waitS(bit r, int ch, logic v, int lim);
        n = 0;
        while ((r ? regulatorReadyOutput[ch] : pwmEnable[ch]) !== v && n < lim)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic rdy(int ch, int lim);
        waitS(0, ch, 1'b1, lim);
        chk("pwmOn", 1'b1, n < lim);
        waitS(1, ch, 1'b1, 20);
        chk("tonDelay", 1'b1, n inside {[5:6]});
    endtask
    function automatic logic [7:0] expCode(int ch);
        return cfg[ch].restartBootSelect ? cfg[ch].bootVoltageValue : cfg[ch].programmedCode;
    endfunction

    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #200000;
        nFail++;
        test_done();
    end
    initial
    begin
        void'($urandom(32'h9B6A921A));
        detRaw = '0;
        prebiasOvRaw = 1'b1;
        initDone = 1'b0;
        enableCmd = 2'h0;
        serviceEn = 1'b0;
        for (int c = 0; c < 2; c++)
        begin
            cfg[c] = '0;
            cfg[c].tonDelay = 16'h0004;
            cfg[c].programmedCode = 8'($urandom);
            cfg[c].bootVoltageValue = 8'($urandom);
        end
        doReset();
        wt(40);
        chk("prebias", 1'b1, prebiasStatus);
        chk("prebiasPin", 1'b0, faultOutputPin_n);
        chk("prebiasPwm", 2'h0, pwmEnable);
        prebiasOvRaw = 1'b0;
        initDone = 1'b1;
        doReset();
        chk("prebiasRst", 1'b0, prebiasStatus);
        enableCmd[0] = 1'b1;
        rdy(0, 20);
        enableCmd[1] = 1'b1;
        rdy(1, 20);
        for (int i = 0; i < 6; i++)
        begin
            w = (i < 2) ? i : $urandom_range(1, 0);
            m = (i == 0) ? 1'b0 : 1'($urandom_range(1, 0));
            cfg[0].alertMask = m ? 4'(1 << w) : 4'h0;
            detRaw[0][w] = 1'b1;
            wt(300);
            chk("warnStat", 1'b1, status[0][w]);
            chk("warnRun", 1'b1, regulatorReadyOutput[0]);
            chk("alert", m, smbAlert_n);
            if (i == 0)
            begin
                service();
                chk("retrigger", 1'b1, status[0][w]);
            end
            detRaw[0][w] = 1'b0;
            wt(10);
            if (m)
            begin
                enableCmd[0] = 1'b0;
                wt(4);
                chk("offClear", 4'h0, status[0]);
                enableCmd[0] = 1'b1;
                rdy(0, 20);
            end
            else
            begin
                service();
                chk("araAddr", 7'h2A, seenAddr);
                chk("hostClear", 4'h0, status[0]);
            end
            chk("alertOff", 1'b1, smbAlert_n);
        end
        cfg[0].alertMask = 4'h0;
        cfg[0].trackOvResp = fault_pkg::RESP_LATCH;
        cfg[0].restartBootSelect = 1'($urandom_range(1, 0));
        detRaw[0].trackOv = 1'b1;
        waitS(0, 0, 1'b0, 200);
        chk("ovLatency", 1'b1, n inside {[120:135]});
        chk("readyLow", 1'b0, regulatorReadyOutput[0]);
        chk("otherRuns", 1'b1, pwmEnable[1]);
        chk("faultPin", 1'b0, faultOutputPin_n);
        detRaw[0].trackOv = 1'b0;
        wt(100);
        chk("latched", 1'b0, pwmEnable[0]);
        enableCmd[0] = 1'b0;
        wt(2);
        enableCmd[0] = 1'b1;
        rdy(0, 20);
        chk("code", expCode(0), targetVoltageCode[0]);
        cfg[1].trackOvResp = fault_pkg::RESP_HICCUP;
        cfg[1].restartBootSelect = ~cfg[0].restartBootSelect;
        detRaw[1].trackOv = 1'b1;
        waitS(0, 1, 1'b0, 200);
        waitS(0, 1, 1'b1, 100);
        chk("hiccupGap", 1'b1, n inside {[49:55]});
        waitS(0, 1, 1'b0, 200);
        chk("hiccupAgain", 1'b1, n inside {[125:145]});
        detRaw[1].trackOv = 1'b0;
        rdy(1, 100);
        chk("code", expCode(1), targetVoltageCode[1]);
        cfg[0].fixedOvResp = fault_pkg::RESP_HYSTERETIC;
        detRaw[0].fixedOv = 1'b1;
        waitS(0, 0, 1'b0, 200);
        chk("fixedLatency", 1'b1, n inside {[120:135]});
        wt(200);
        chk("hystHold", 1'b0, pwmEnable[0]);
        detRaw[0].fixedOv = 1'b0;
        rdy(0, 10);
        service();
        detRaw[1].fixedOv = 1'b1;
        wt(150);
        chk("ignoreStat", 1'b1, status[1][3]);
        chk("ignoreRun", 1'b1, regulatorReadyOutput[1]);
        detRaw[1].fixedOv = 1'b0;
        wt(10);
        enableCmd[1] = 1'b0;
        cfg[1].fixedOvResp = fault_pkg::RESP_LATCH;
        detRaw[1].fixedOv = 1'b1;
        wt(150);
        detRaw[1].fixedOv = 1'b0;
        service();
        chk("lockStat", 1'b1, status[1][3]);
        chk("lockPin", 1'b0, faultOutputPin_n);
        doReset();
        chk("lockReset", 4'h0, status[1]);
        test_done();
    end
endmodule  // fault_response_manager_tb_top
